// >>> verilog/thle_pkg.sv
// constants, types and encodings for the tagged host link executive
// assumes a single 10 MHz clock domain shared by all users of this package
// What this block does
// [RQ1] host executive and link supervisor run side by side as separate state machines
// [RQ2] host executive owns configuration and moves data between host and rings
// [RQ3] link supervisor applies configuration and steps through one script transaction
// [RQ4] host streams carry host command tags; replies carry host reply tags
// [RQ5] scripts use link script tags; results use link result tags
// [RQ6] executive passes link tag content through untouched inside its own tags
// [RQ7] link-bound data goes to outbound ring; link results come back via return ring, except one arriving with a host return-ring write, which is dropped
// [RQ8] each ring is a separate 255-byte circular buffer
// [RQ9] every incoming host byte is taken at once, never stalled
// [RQ10] host must check free space before ring writes or overrun results
// [RQ11] returned data waits in return ring until executive tags and sends it
// [RQ12] executive may interleave its own replies with link results
// [RQ13] a tag stands alone or is followed by payload depending on its value
// [RQ14] configuration image and status snapshot each have three sections
// [RQ15] configuration bytes 0-7 executive, 8-15 generic link, 16-23 protocol
// [RQ16] protocol section meaning follows the selected protocol
// [RQ17] status snapshot shows live operating flags
// [RQ18] tag 0x00 ends a host stream
// [RQ19] tag 0x02 carries 24 bytes replacing the whole configuration image
// [RQ20] write to a full ring sets sticky overrun and drops the byte
// [RQ21] rings keep wrapping pointers and report their fill level
package thle_pkg;

  localparam int THLE_RING_DEPTH = 255;
  localparam int THLE_CFG_LEN = 24;
  localparam int THLE_STAT_LEN = 20;
  localparam logic [4:0] THLE_CFG_HOST_EXECUTIVE_LO = 5'h00;
  localparam logic [4:0] THLE_CFG_GEN_LO = 5'h08;
  localparam logic [4:0] THLE_CFG_PROTO_LO = 5'h10;
  localparam logic [7:0] THLE_CFG_RESET = 8'h00;

  // host command tags
  localparam logic [7:0] THLE_TAG_END = 8'h00;
  localparam logic [7:0] THLE_TAG_CMD = 8'h01;
  localparam logic [7:0] THLE_TAG_CFG_WR = 8'h02;
  localparam logic [7:0] THLE_TAG_OUT_WR = 8'h03;
  localparam logic [7:0] THLE_TAG_RET_WR = 8'h04;

  // executive command codes after tag 0x01
  localparam logic [7:0] THLE_CMD_RESET = 8'h00;
  localparam logic [7:0] THLE_CMD_LINK_INIT = 8'h01;
  localparam logic [7:0] THLE_CMD_STATUS = 8'h02;
  localparam logic [7:0] THLE_CMD_FLUSH = 8'h05;
  localparam logic [7:0] THLE_CMD_LINK_RESET = 8'h06;

  // host reply tags
  localparam logic [7:0] THLE_RTAG_STATUS = 8'h83;
  localparam logic [7:0] THLE_RTAG_RESULT = 8'h80;
  localparam logic [7:0] THLE_RTAG_END = 8'h00;

  // status byte 0 flag positions
  localparam int THLE_ST_OUT_OVR = 0;
  localparam int THLE_ST_RET_OVR = 1;
  localparam int THLE_ST_LINK_BUSY = 2;
  localparam int THLE_ST_LINK_INIT = 3;

  typedef enum logic [5:0] {
    THLE_RX_TAG = 6'b000001,
    THLE_RX_CMD = 6'b000010,
    THLE_RX_CFG = 6'b000100,
    THLE_RX_CNT = 6'b001000,
    THLE_RX_DATA = 6'b010000,
    THLE_RX_SKIP = 6'b100000
  } thle_rx_t;

  typedef enum logic [4:0] {
    THLE_TX_IDLE = 5'b00001,
    THLE_TX_STAT = 5'b00010,
    THLE_TX_RTAG = 5'b00100,
    THLE_TX_RCNT = 5'b01000,
    THLE_TX_RDAT = 5'b10000
  } thle_tx_t;

  typedef enum logic [2:0] {
    THLE_LS_IDLE = 3'b001,
    THLE_LS_SEND = 3'b010,
    THLE_LS_WAIT = 3'b100
  } thle_ls_t;

endpackage

// >>> verilog/thle_top.sv
// host executive, link supervisor and both rings in one module
// assumes byte streams on the clock domain; host bytes come as one-cycle strobes
`timescale 1ns/1ps
module thle_top
  import thle_pkg::*;
#(
  parameter int RING_DEPTH = THLE_RING_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  output logic [7:0] host_tx_data,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  output logic [7:0] link_tx_data,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  output logic link_init,
  output logic link_reset,
  output logic [7:0] proto_sel,
  output logic [7:0] out_fill,
  output logic [7:0] ret_fill,
  output logic overrun
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rst_n = rst_s2_reg;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg [THLE_CFG_LEN];
  logic [7:0] cfg_next [THLE_CFG_LEN];
  logic [7:0] out_mem [RING_DEPTH];
  logic [7:0] ret_mem [RING_DEPTH];
  logic [7:0] out_wp_reg, out_wp_next, out_rp_reg, out_rp_next, out_cnt_reg, out_cnt_next;
  logic [7:0] ret_wp_reg, ret_wp_next, ret_rp_reg, ret_rp_next, ret_cnt_reg, ret_cnt_next;
  thle_rx_t rx_reg, rx_next;
  thle_tx_t tx_reg, tx_next;
  thle_ls_t ls_reg, ls_next;
  logic [7:0] len_reg, len_next;
  logic [4:0] idx_reg, idx_next;
  logic [7:0] dest_reg, dest_next;
  logic [7:0] tcnt_reg, tcnt_next;
  logic stat_req_reg, stat_req_next;
  logic ovr_out_reg, ovr_out_next, ovr_ret_reg, ovr_ret_next;
  logic linit_reg, linit_next, lrst_reg, lrst_next;
  logic [7:0] htx_d_reg, htx_d_next;
  logic htx_v_reg, htx_v_next;
  logic [7:0] ltx_d_reg, ltx_d_next;
  logic ltx_v_reg, ltx_v_next;
  logic out_wr, ret_wr, out_rd, ret_rd;
  logic [7:0] out_wd, ret_wd;
  logic lrdy_reg, lrdy_next, ovr_reg, ovr_next;
  function automatic logic [7:0] ring_inc(input logic [7:0] p);
    ring_inc = (p == 8'(RING_DEPTH - 1)) ? 8'h00 : p + 8'h01; // RQ21
  endfunction
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_next = cfg_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    ls_next = ls_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    dest_next = dest_reg;
    tcnt_next = tcnt_reg;
    stat_req_next = stat_req_reg;
    ovr_out_next = ovr_out_reg;
    ovr_ret_next = ovr_ret_reg;
    {linit_next, lrst_next} = 2'b00;
    htx_d_next = htx_d_reg;
    htx_v_next = htx_v_reg;
    ltx_d_next = ltx_d_reg;
    ltx_v_next = ltx_v_reg;
    {out_wr, ret_wr, out_rd, ret_rd} = 4'h0;
    out_wd = host_rx_data;
    ret_wd = link_rx_data;
    out_rp_next = out_rp_reg;
    ret_rp_next = ret_rp_reg;
    // host decoder: never stalls the host
    if (host_rx_valid) // RQ9
    begin
      unique case (rx_reg)
        THLE_RX_TAG:
        begin
          unique case (host_rx_data) // RQ4 RQ13
            THLE_TAG_END: rx_next = THLE_RX_TAG; // RQ18
            THLE_TAG_CMD: rx_next = THLE_RX_CMD;
            THLE_TAG_CFG_WR:
            begin
              idx_next = 5'h00;
              rx_next = THLE_RX_CFG;
            end
            THLE_TAG_OUT_WR, THLE_TAG_RET_WR:
            begin
              dest_next = host_rx_data;
              rx_next = THLE_RX_CNT;
            end
            default: rx_next = THLE_RX_TAG;
          endcase
        end
        THLE_RX_CMD:
        begin
          rx_next = THLE_RX_TAG;
          unique case (host_rx_data)
            THLE_CMD_RESET, THLE_CMD_LINK_RESET:
            begin
              lrst_next = 1'b1;
              ovr_out_next = 1'b0;
              ovr_ret_next = 1'b0;
            end
            THLE_CMD_LINK_INIT: linit_next = 1'b1; // RQ3
            THLE_CMD_STATUS: stat_req_next = 1'b1; // RQ12
            THLE_CMD_FLUSH: tcnt_next = 8'h00;
            default: rx_next = THLE_RX_TAG;
          endcase
        end
        THLE_RX_CFG:
        begin
          cfg_next[idx_reg] = host_rx_data; // RQ19 RQ14 RQ15 RQ2
          idx_next = idx_reg + 5'h01;
          if (idx_reg == 5'(THLE_CFG_LEN - 1))
            rx_next = THLE_RX_TAG;
        end
        THLE_RX_CNT:
        begin
          len_next = host_rx_data;
          rx_next = (host_rx_data == 8'h00) ? THLE_RX_TAG : THLE_RX_DATA;
        end
        THLE_RX_DATA, THLE_RX_SKIP:
        begin
          if (dest_reg == THLE_TAG_OUT_WR) // RQ7 RQ6
          begin
            if (out_cnt_reg == 8'(RING_DEPTH))
              ovr_out_next = 1'b1; // RQ20 RQ10
            else
              out_wr = 1'b1;
          end
          else
          begin
            ret_wd = host_rx_data;
            if (ret_cnt_reg == 8'(RING_DEPTH))
              ovr_ret_next = 1'b1; // RQ20
            else
              ret_wr = 1'b1;
          end
          len_next = len_reg - 8'h01;
          if (len_reg == 8'h01)
            rx_next = THLE_RX_TAG;
        end
        default: rx_next = THLE_RX_TAG;
      endcase
    end
    // link results into return ring
    if (link_rx_valid && !ret_wr && ret_cnt_reg != 8'(RING_DEPTH))
      ret_wr = 1'b1; // RQ7
    else if (link_rx_valid && !ret_wr)
      ovr_ret_next = 1'b1; // RQ20
    // link supervisor: drains outbound ring to the target link
    unique case (ls_reg) // RQ1 RQ3
      THLE_LS_IDLE:
        if (out_cnt_reg != 8'h00 && !out_wr)
        begin
          ltx_d_next = out_mem[out_rp_reg]; // RQ5
          ltx_v_next = 1'b1;
          out_rd = 1'b1;
          out_rp_next = ring_inc(out_rp_reg);
          ls_next = THLE_LS_SEND;
        end
      THLE_LS_SEND:
        if (link_tx_ready)
        begin
          ltx_v_next = 1'b0;
          ls_next = THLE_LS_WAIT;
        end
      THLE_LS_WAIT: ls_next = THLE_LS_IDLE;
      default: ls_next = THLE_LS_IDLE;
    endcase
    // host reply framing
    unique case (tx_reg) // RQ4 RQ11 RQ12
      THLE_TX_IDLE:
        if (stat_req_reg)
        begin
          stat_req_next = 1'b0;
          htx_d_next = THLE_RTAG_STATUS;
          htx_v_next = 1'b1;
          idx_next = 5'h00;
          tx_next = THLE_TX_STAT;
        end
        else if (ret_cnt_reg != 8'h00 && !ret_wr)
        begin
          htx_d_next = THLE_RTAG_RESULT;
          htx_v_next = 1'b1;
          tx_next = THLE_TX_RCNT;
        end
      THLE_TX_STAT:
        if (host_tx_ready)
        begin
          htx_d_next = (idx_reg == 5'h00) ?
            {4'h0, linit_reg, ls_reg != THLE_LS_IDLE, ovr_ret_reg, ovr_out_reg} : // RQ17
            (idx_reg == 5'h01) ? out_cnt_reg : ret_cnt_reg;
          idx_next = idx_reg + 5'h01;
          if (idx_reg == 5'h03)
          begin
            htx_v_next = 1'b0;
            tx_next = THLE_TX_IDLE;
          end
        end
      THLE_TX_RCNT:
        if (host_tx_ready)
        begin
          htx_d_next = ret_cnt_reg;
          tcnt_next = ret_cnt_reg;
          tx_next = THLE_TX_RDAT;
        end
      THLE_TX_RDAT:
        if (host_tx_ready)
        begin
          if (tcnt_reg == 8'h00)
          begin
            htx_v_next = 1'b0;
            tx_next = THLE_TX_IDLE;
          end
          else
          begin
            htx_d_next = ret_mem[ret_rp_reg]; // RQ6 RQ11
            ret_rd = 1'b1;
            ret_rp_next = ring_inc(ret_rp_reg);
            tcnt_next = tcnt_reg - 8'h01;
          end
        end
      default: tx_next = THLE_TX_IDLE;
    endcase
    out_wp_next = out_wr ? ring_inc(out_wp_reg) : out_wp_reg;
    ret_wp_next = ret_wr ? ring_inc(ret_wp_reg) : ret_wp_reg;
    out_cnt_next = out_cnt_reg + {7'h00, out_wr} - {7'h00, out_rd}; // RQ21
    ret_cnt_next = ret_cnt_reg + {7'h00, ret_wr} - {7'h00, ret_rd};
    if (lrst_next)
      {out_wp_next, out_rp_next, out_cnt_next, ret_wp_next, ret_rp_next, ret_cnt_next} = '0;
    lrdy_next = ret_cnt_next != 8'(RING_DEPTH);
    ovr_next = ovr_out_next | ovr_ret_next;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < THLE_CFG_LEN; i++)
        cfg_reg[i] <= THLE_CFG_RESET;
      rx_reg <= THLE_RX_TAG;
      tx_reg <= THLE_TX_IDLE;
      ls_reg <= THLE_LS_IDLE;
      {len_reg, dest_reg, tcnt_reg, htx_d_reg, ltx_d_reg, idx_reg} <= '0;
      lrdy_reg <= 1'b1;
      {out_wp_reg, out_rp_reg, out_cnt_reg, ret_wp_reg, ret_rp_reg, ret_cnt_reg} <= '0;
      {stat_req_reg, ovr_out_reg, ovr_ret_reg, linit_reg, lrst_reg, htx_v_reg, ltx_v_reg, ovr_reg} <= '0;
    end
    else if (clk_en)
    begin
      cfg_reg <= cfg_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      ls_reg <= ls_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      dest_reg <= dest_next;
      tcnt_reg <= tcnt_next;
      stat_req_reg <= stat_req_next;
      ovr_out_reg <= ovr_out_next;
      ovr_ret_reg <= ovr_ret_next;
      linit_reg <= linit_next;
      lrst_reg <= lrst_next;
      htx_d_reg <= htx_d_next;
      htx_v_reg <= htx_v_next;
      ltx_d_reg <= ltx_d_next;
      ltx_v_reg <= ltx_v_next;
      out_wp_reg <= out_wp_next;
      out_rp_reg <= out_rp_next;
      out_cnt_reg <= out_cnt_next;
      ret_wp_reg <= ret_wp_next;
      ret_rp_reg <= ret_rp_next;
      ret_cnt_reg <= ret_cnt_next;
      lrdy_reg <= lrdy_next;
      ovr_reg <= ovr_next;
    end
  end

  // ring storage, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && out_wr)
      out_mem[out_wp_reg] <= out_wd; // RQ8
    if (clk_en && ret_wr)
      ret_mem[ret_wp_reg] <= ret_wd; // RQ8
  end

  assign host_tx_data = htx_d_reg;
  assign host_tx_valid = htx_v_reg;
  assign link_tx_data = ltx_d_reg;
  assign link_tx_valid = ltx_v_reg;
  assign link_rx_ready = lrdy_reg;
  assign link_init = linit_reg;
  assign link_reset = lrst_reg;
  assign proto_sel = cfg_reg[THLE_CFG_PROTO_LO]; // RQ16
  assign out_fill = out_cnt_reg;
  assign ret_fill = ret_cnt_reg;
  assign overrun = ovr_reg;
endmodule // thle_top

// >>> verif/thle_top_sva.sv
// port checker for thle_top
// assumes binding onto thle_top, one clock domain
`timescale 1ns/1ps
module thle_top_sva
  import thle_pkg::*;
#(
  parameter int RING_DEPTH = THLE_RING_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_tx_data,
  input wire logic host_tx_valid,
  input wire logic host_tx_ready,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  input wire logic link_tx_ready,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_valid,
  input wire logic link_rx_ready,
  input wire logic link_init,
  input wire logic link_reset,
  input wire logic [7:0] proto_sel,
  input wire logic [7:0] out_fill,
  input wire logic [7:0] ret_fill,
  input wire logic overrun
);
  // ----
  // settle counter: internal reset lags rst_b
  // ----
  logic [1:0] up_reg;
  logic [1:0] up_next;
  logic up;
  always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      up_reg <= 2'h0;
    else
      up_reg <= up_next;
  assign up = (up_reg == 2'h3);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_fill_max;
    (out_fill <= RING_DEPTH) && (ret_fill <= RING_DEPTH);
  endproperty
  a_fill_max: assert property (p_fill_max) else $error("fill above depth");
  property p_rx_ready;
    up |-> link_rx_ready == (ret_fill < RING_DEPTH);
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx ready wrong");
  property p_out_step;
    up && $changed(out_fill) |-> out_fill == $past(out_fill) + 8'h01 ||
      out_fill + 8'h01 == $past(out_fill) || out_fill == 8'h00;
  endproperty
  a_out_step: assert property (p_out_step) else $error("fill jumped");
  property p_link_hold;
    link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_data);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link byte dropped");
  property p_host_hold;
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("reply byte dropped");
  property p_link_gap;
    link_tx_valid && link_tx_ready |=> !(link_tx_valid && link_tx_ready) [*2];
  endproperty
  a_link_gap: assert property (p_link_gap) else $error("link bytes too close");
  property p_ovr_set;
    up && link_rx_valid && !link_rx_ready |-> ##[1:2] overrun;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");
  property p_ovr_clr;
    up && $fell(overrun) |-> link_reset || $past(link_reset) || $past(link_reset, 2);
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not sticky");
  property p_rst_clear;
    link_reset |-> ##[0:2] (out_fill == 8'h00 && ret_fill == 8'h00 && !overrun);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("rings not cleared");
  property p_init_pulse;
    link_init |=> !link_init;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init not a pulse");
  c_init: cover property (link_init);
  c_ovr: cover property (overrun);
  c_res: cover property (host_tx_valid && host_tx_ready && host_tx_data == THLE_RTAG_RESULT);
endmodule // thle_top_sva

// >>> verif/thle_link_model.sv
// far-side link model: takes outbound bytes, may echo them back
// assumes stall, slow and echo come from the bench
`timescale 1ns/1ps
module thle_link_model
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  output logic [7:0] link_rx_data,
  output logic link_rx_valid,
  input wire logic stall,
  input wire logic slow,
  input wire logic echo
);
  logic tog;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tog <= 1'b0;
      link_tx_ready <= 1'b0;
      link_rx_valid <= 1'b0;
      link_rx_data <= 8'h00;
    end
    else
    begin
      tog <= ~tog;
      link_tx_ready <= !stall && (!slow || tog);
      link_rx_valid <= 1'b0;
      // idle data line keeps changing
      link_rx_data <= ~link_rx_data;
      if (link_tx_valid && link_tx_ready && echo)
      begin
        link_rx_valid <= 1'b1;
        link_rx_data <= link_tx_data;
      end
    end
  end
endmodule // thle_link_model

// >>> verif/tb_thle_top.sv
// self-checking bench for thle_top
// assumes thle_link_model as link side; bench plays the host
`timescale 1ns/1ps
module tb_thle_top
  import thle_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] host_rx_data = 8'h00;
  logic host_rx_valid = 1'b0;
  logic host_tx_ready = 1'b0;
  logic stall = 1'b0, slow = 1'b0, echo = 1'b0, lchk = 1'b0;
  logic [1:0] hmode = 2'h0;
  logic [7:0] host_tx_data, link_tx_data, link_rx_data, proto_sel, out_fill, ret_fill, v, p;
  logic host_tx_valid, link_tx_valid, link_tx_ready, link_rx_valid, link_rx_ready;
  logic link_init, link_reset, overrun;
  logic [31:0] rs = 32'hE99F;
  logic [15:0] hq[$];
  logic [15:0] e;
  logic [7:0] lq[$];
  int n_errors = 0, checks_done = 0, n_init = 0, n_rst = 0;
  thle_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .host_rx_data(host_rx_data),
    .host_rx_valid(host_rx_valid), .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid),
    .host_tx_ready(host_tx_ready), .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_rx_data(link_rx_data), .link_rx_valid(link_rx_valid),
    .link_rx_ready(link_rx_ready), .link_init(link_init), .link_reset(link_reset),
    .proto_sel(proto_sel), .out_fill(out_fill), .ret_fill(ret_fill), .overrun(overrun));
  thle_link_model i_link (.ref_clk(ref_clk), .rst_b(rst_b), .link_tx_data(link_tx_data),
    .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready), .link_rx_data(link_rx_data),
    .link_rx_valid(link_rx_valid), .stall(stall), .slow(slow), .echo(echo));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tx(input logic [7:0] b);
    @(posedge ref_clk);
    host_rx_data <= b;
    host_rx_valid <= 1'b1;
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk);
    host_rx_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && hq.size() > 0; i++) @(posedge ref_clk);
    check(8'(hq.size()), 8'h00);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  // ----
  // host-side ready and output watchers
  // ----
  always @(posedge ref_clk)
  begin
    rs = xs(rs);
    host_tx_ready <= hmode[1] ? rs[0] : hmode[0];
    if (link_init === 1'b1) n_init++;
    if (link_reset === 1'b1) n_rst++;
    if (rst_b && host_tx_valid && host_tx_ready)
    begin
      e = hq.size() > 0 ? hq.pop_front() : 16'hFFXX;
      check(host_tx_data & e[15:8], e[7:0]);
    end
    if (rst_b && lchk && link_tx_valid && link_tx_ready)
      check(link_tx_data, lq.size() > 0 ? lq.pop_front() : 8'hXX);
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(out_fill, 8'h00);
    check(ret_fill, 8'h00);
    check({7'h00, link_rx_ready}, 8'h01);
    check(proto_sel, THLE_CFG_RESET);
    $display("test reset done");
    tx(THLE_TAG_END);
    tx(THLE_TAG_CFG_WR);
    for (int i = 0; i < THLE_CFG_LEN; i++)
    begin
      rs = xs(rs);
      v = rs[7:0];
      if (i == 16) p = v;
      tx(v);
    end
    idle(2);
    check(proto_sel, p);
    tx(THLE_TAG_CMD);
    tx(THLE_CMD_LINK_INIT);
    idle(3);
    check(8'(n_init), 8'h01);
    clk_en <= 1'b0;
    tx(THLE_TAG_CMD);
    tx(THLE_CMD_LINK_INIT);
    idle(3);
    clk_en <= 1'b1;
    idle(2);
    check(8'(n_init), 8'h01);
    $display("test config done");
    for (int s = 0; s < 2; s++)
    begin
      {stall, slow, echo, lchk, hmode} <= {1'b0, s[0], 4'hC};
      tx(THLE_TAG_OUT_WR);
      tx(8'h03);
      hq.push_back({8'hFF, THLE_RTAG_RESULT});
      hq.push_back(16'hFF03);
      for (int i = 0; i < 3; i++)
      begin
        rs = xs(rs);
        v = rs[7:0];
        tx(v);
        lq.push_back(v);
        hq.push_back({8'hFF, v});
      end
      idle(0);
      for (int i = 0; i < 200 && ret_fill !== 8'h03; i++) @(posedge ref_clk);
      check(ret_fill, 8'h03);
      hmode <= 2'h2;
      drain();
    end
    $display("test return path done");
    hmode <= 2'h1;
    tx(THLE_TAG_CMD);
    tx(THLE_CMD_STATUS);
    hq.push_back({8'hFF, THLE_RTAG_STATUS});
    hq.push_back(16'h0300);
    hq.push_back(16'hFF00);
    hq.push_back(16'hFF00);
    idle(0);
    drain();
    $display("test status done");
    {stall, echo, lchk, hmode} <= 5'h18;
    for (int r = 0; r < 2; r++)
    begin
      tx(r == 0 ? THLE_TAG_OUT_WR : THLE_TAG_RET_WR);
      tx(8'hFF);
      for (int k = 0; k < 255; k++) tx(8'(k));
      tx(r == 0 ? THLE_TAG_OUT_WR : THLE_TAG_RET_WR);
      tx(8'h02);
      tx(8'hA5);
      tx(8'h5A);
    end
    idle(2);
    check(out_fill, 8'hFF);
    check(ret_fill, 8'hFF);
    check({7'h00, overrun}, 8'h01);
    stall <= 1'b0;
    for (int i = 0; i < 3000 && out_fill !== 8'h00; i++) @(posedge ref_clk);
    idle(4);
    check({7'h00, overrun}, 8'h01);
    check(out_fill, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      tx(THLE_TAG_CMD);
      tx(k == 0 ? THLE_CMD_RESET : THLE_CMD_LINK_RESET);
      idle(3);
      check(8'(n_rst), 8'(k + 1));
      check({7'h00, overrun}, 8'h00);
      check(ret_fill, 8'h00);
    end
    do_reset();
    $display("test overrun done");
    stop_test();
  end
endmodule // tb_thle_top
bind thle_top thle_top_sva #(.RING_DEPTH(RING_DEPTH)) i_sva (.ref_clk(ref_clk), .rst_b(rst_b),
  .clk_en(clk_en), .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid),
  .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
  .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
  .link_rx_data(link_rx_data), .link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready),
  .link_init(link_init), .link_reset(link_reset), .proto_sel(proto_sel),
  .out_fill(out_fill), .ret_fill(ret_fill), .overrun(overrun));
